/* File: cbs_sequencer.sv */
// Purpose: bus-cycle sequencer, drives memory-interface signals row by row
// Assumes: issue data is valid with issue_valid; mem_wait stretches the current row
// Notes:   bus and side outputs are registered and show the row of the current cycle
`timescale 1ns/10ps
`default_nettype none

module cbs_sequencer
	import cbs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       issue_valid,
	input  wire cbs_issue_t issue,
	input  wire logic       mem_wait,
	output logic            issue_ready,
	output logic            issue_reject,
	output cbs_bus_t        bus,
	output cbs_side_t       side
);

	// ****************************************************************
	// state
	// ****************************************************************

	cbs_state_t       st_r,     st_nxt;
	cbs_issue_t       ir_r,     ir_nxt;
	logic [CNT_W-1:0] cnt_r,    cnt_nxt;
	logic [CNT_W-1:0] total_r,  total_nxt;
	logic             cmp_r,    cmp_nxt;
	cbs_bus_t         bus_r,    bus_nxt;
	cbs_side_t        side_r,   side_nxt;
	logic             reject_r, reject_nxt;

	logic [CNT_W-1:0] issue_total;
	logic             issue_illegal;
	logic             last;
	logic             accept;

	// ****************************************************************
	// timing and row address helpers
	// ****************************************************************

	logic [ADDR_W-1:0] row_base;
	logic [1:0]        row_step;
	logic [ADDR_W-1:0] row_width;
	logic [ADDR_W-1:0] row_addr;

	cbs_op_timing u_timing (
		.ir      (issue),
		.compact (cmp_r),
		.total   (issue_total),
		.illegal (issue_illegal)
	);

	cbs_addr_step u_step (
		.base  (row_base),
		.step  (row_step),
		.width (row_width),
		.sum   (row_addr)
	);

	// ****************************************************************
	// sequence control
	// ****************************************************************

	assign last        = (st_r == ST_RUN) && (cnt_r == total_r);
	assign issue_ready = !mem_wait && ((st_r == ST_IDLE) || last);
	assign accept      = issue_valid && issue_ready && !issue_illegal;

	always_comb begin
		st_nxt     = st_r;
		ir_nxt     = ir_r;
		cnt_nxt    = cnt_r;
		total_nxt  = total_r;
		cmp_nxt    = cmp_r;
		reject_nxt = 1'b0;
		if (mem_wait) begin
			// hold the row while memory extends it
			st_nxt = st_r;
		end else if ((st_r == ST_RUN) && !last) begin
			cnt_nxt = cnt_r + CYCLE_1;
			if ((ir_r.op == OP_BR_SWITCH) && (cnt_nxt == CYCLE_2)) begin
				cmp_nxt = ir_r.target[0];
			end
		end else if (accept) begin
			st_nxt    = ST_RUN;
			ir_nxt    = issue;
			cnt_nxt   = CYCLE_1;
			total_nxt = issue_total;
			if ((issue.op == OP_STAT_READ) || (issue.op == OP_STAT_WRITE)) begin
				ir_nxt.dest_pc = 1'b0;
			end
		end else begin
			st_nxt     = ST_IDLE;
			cnt_nxt    = CYCLE_1;
			reject_nxt = issue_valid && issue_ready && issue_illegal;
		end
	end

	// ****************************************************************
	// row contents for the coming cycle
	// ****************************************************************

	always_comb begin
		row_base  = ir_nxt.pc;
		row_step  = STEP_2;
		row_width = cmp_nxt ? WIDTH_COMPACT : WIDTH_WIDE;
		bus_nxt   = bus_r;
		side_nxt  = '0;
		bus_nxt.write_not_read     = 1'b0;
		bus_nxt.instr_fetch_low    = 1'b0;
		bus_nxt.mem_request_low    = 1'b0;
		bus_nxt.burst_continue_flag = 1'b0;
		if (mem_wait) begin
			bus_nxt  = bus_r;
			side_nxt = side_r;
		end else if (st_nxt == ST_IDLE) begin
			row_base = bus_r.addr;
			row_step = STEP_0;
			bus_nxt.instr_fetch_low = 1'b1;
			bus_nxt.mem_request_low = 1'b1;
		end else begin
			case (ir_nxt.op)
				OP_BR_SWITCH: begin
					case (cnt_nxt)
						CYCLE_1: begin
							// prefetch with old width and old flag
							row_step = STEP_2;
						end
						CYCLE_2: begin
							row_base = ir_nxt.target & TARGET_MASK;
							row_step = STEP_0;
							bus_nxt.burst_continue_flag = 1'b1;
						end
						default: begin
							row_base = ir_nxt.target & TARGET_MASK;
							row_step = STEP_1;
							bus_nxt.burst_continue_flag = 1'b1;
						end
					endcase
				end
				OP_DATA, OP_STAT_READ, OP_STAT_WRITE: begin
					if (ir_nxt.dest_pc && ir_nxt.shift_reg) begin
						case (cnt_nxt)
							CYCLE_1: begin
								bus_nxt.mem_request_low = 1'b1;
							end
							CYCLE_2: begin
								row_step = STEP_3;
								bus_nxt.instr_fetch_low = 1'b1;
							end
							CYCLE_3: begin
								row_base = ir_nxt.target;
								row_step = STEP_0;
								bus_nxt.burst_continue_flag = 1'b1;
								side_nxt.exc_ignore = 1'b1;
							end
							default: begin
								row_base = ir_nxt.target;
								row_step = STEP_1;
								bus_nxt.burst_continue_flag = 1'b1;
								side_nxt.exc_ignore = 1'b1;
							end
						endcase
					end else if (ir_nxt.dest_pc) begin
						case (cnt_nxt)
							CYCLE_1: begin
								// flush: non-sequential ahead of the target fetch
								bus_nxt.burst_continue_flag = 1'b0;
							end
							CYCLE_2: begin
								row_base = ir_nxt.target;
								row_step = STEP_0;
								bus_nxt.burst_continue_flag = 1'b1;
								side_nxt.exc_ignore = 1'b1;
							end
							default: begin
								row_base = ir_nxt.target;
								row_step = STEP_1;
								bus_nxt.burst_continue_flag = 1'b1;
								side_nxt.exc_ignore = 1'b1;
							end
						endcase
					end else if (ir_nxt.shift_reg) begin
						case (cnt_nxt)
							CYCLE_1: begin
								bus_nxt.mem_request_low = 1'b1;
							end
							default: begin
								// address moves on to pc+3L so the internal cycle can merge
								row_step = STEP_3;
								bus_nxt.instr_fetch_low = 1'b1;
								bus_nxt.burst_continue_flag = 1'b1;
							end
						endcase
					end else begin
						bus_nxt.burst_continue_flag = 1'b1;
					end
					if (cnt_nxt == CYCLE_1) begin
						side_nxt.pc_advance = 1'b1;
					end
					if ((cnt_nxt == total_nxt) && !ir_nxt.dest_pc) begin
						// compare and test only touch the arithmetic flags
						side_nxt.dest_write   = !ir_nxt.compare && (ir_nxt.op != OP_STAT_WRITE);
						side_nxt.flags_update = (ir_nxt.op == OP_DATA);
					end else if (cnt_nxt == CYCLE_1) begin
						side_nxt.dest_write   = ir_nxt.dest_pc && !ir_nxt.compare;
						side_nxt.flags_update = ir_nxt.dest_pc && (ir_nxt.op == OP_DATA);
					end
				end
				OP_MUL, OP_MLA, OP_MULL, OP_MLAL: begin
					if (cnt_nxt == CYCLE_1) begin
						bus_nxt.mem_request_low = 1'b1;
						side_nxt.pc_advance     = 1'b1;
					end else if (cnt_nxt == total_nxt) begin
						row_step = STEP_3;
						bus_nxt.instr_fetch_low     = 1'b1;
						bus_nxt.burst_continue_flag = 1'b1;
						side_nxt.dest_write         = 1'b1;
					end else begin
						// accumulate forms still show pc+2L in their second row
						if ((cnt_nxt == CYCLE_2) && ((ir_nxt.op == OP_MLA) || (ir_nxt.op == OP_MLAL))) begin
							row_step = STEP_2;
						end else begin
							row_step = STEP_3;
						end
						bus_nxt.instr_fetch_low = 1'b1;
						bus_nxt.mem_request_low = 1'b1;
					end
				end
				default: begin
					row_step = STEP_2;
				end
			endcase
			side_nxt.done = (cnt_nxt == total_nxt);
		end
		if (!mem_wait) begin
			bus_nxt.addr = row_addr;
			bus_nxt.access_size = cmp_nxt ? SIZE_HALF : SIZE_WORD;
			bus_nxt.compact_state_flag = cmp_nxt ? FLAG_COMPACT : FLAG_WIDE;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r     <= ST_IDLE;
			ir_r     <= '0;
			cnt_r    <= CYCLE_1;
			total_r  <= CYCLE_1;
			cmp_r    <= FLAG_WIDE;
			reject_r <= 1'b0;
			side_r   <= '0;
			bus_r.addr                <= '0;
			bus_r.access_size         <= SIZE_WORD;
			bus_r.write_not_read      <= 1'b0;
			bus_r.instr_fetch_low     <= 1'b1;
			bus_r.mem_request_low     <= 1'b1;
			bus_r.burst_continue_flag <= 1'b0;
			bus_r.compact_state_flag  <= FLAG_WIDE;
		end else begin
			st_r     <= st_nxt;
			ir_r     <= ir_nxt;
			cnt_r    <= cnt_nxt;
			total_r  <= total_nxt;
			cmp_r    <= cmp_nxt;
			reject_r <= reject_nxt;
			side_r   <= side_nxt;
			bus_r    <= bus_nxt;
		end
	end

	assign bus          = bus_r;
	assign side         = side_r;
	assign issue_reject = reject_r;

endmodule

`default_nettype wire

/* File: cbs_pkg.sv */
// Purpose: constants, types and encodings shared by the bus-cycle sequencer files
// Assumes: single core clock, synchronous active-high reset
// Notes:   one issued instruction walks through table rows, one row per clock while mem_wait is low

package cbs_pkg;

	localparam int ADDR_W = 32;
	localparam int CNT_W  = 4;
	localparam int MUL_W  = 3;

	// access size codes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// instruction widths in bytes
	localparam logic [ADDR_W-1:0] WIDTH_WIDE    = 32'h4;
	localparam logic [ADDR_W-1:0] WIDTH_COMPACT = 32'h2;

	// compact state flag levels
	localparam logic FLAG_WIDE    = 1'b0;
	localparam logic FLAG_COMPACT = 1'b1;

	// address step counts in instruction widths
	localparam logic [1:0] STEP_0 = 2'h0;
	localparam logic [1:0] STEP_1 = 2'h1;
	localparam logic [1:0] STEP_2 = 2'h2;
	localparam logic [1:0] STEP_3 = 2'h3;

	// row numbers and sequence lengths
	localparam logic [CNT_W-1:0] CYCLE_1 = 4'h1;
	localparam logic [CNT_W-1:0] CYCLE_2 = 4'h2;
	localparam logic [CNT_W-1:0] CYCLE_3 = 4'h3;
	localparam logic [CNT_W-1:0] CYCLE_4 = 4'h4;

	// extra multiply cycles over m+1
	localparam logic [CNT_W-1:0] MUL_EXTRA_NONE = 4'h0;
	localparam logic [CNT_W-1:0] MUL_EXTRA_ONE  = 4'h1;
	localparam logic [CNT_W-1:0] MUL_EXTRA_TWO  = 4'h2;

	// mask clearing the state-select bit of a branch source
	localparam logic [ADDR_W-1:0] TARGET_MASK = 32'hFFFFFFFE;

	typedef enum logic [3:0] {
		OP_DATA       = 4'h0,
		OP_STAT_READ  = 4'h1,
		OP_STAT_WRITE = 4'h2,
		OP_BR_SWITCH  = 4'h3,
		OP_MUL        = 4'h4,
		OP_MLA        = 4'h5,
		OP_MULL       = 4'h6,
		OP_MLAL       = 4'h7
	} cbs_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} cbs_state_t;

	typedef struct packed {
		cbs_op_t            op;
		logic               dest_pc;
		logic               shift_reg;
		logic               compare;
		logic [ADDR_W-1:0]  pc;
		logic [ADDR_W-1:0]  target;
		logic [MUL_W-1:0]   mul_m;
	} cbs_issue_t;

	typedef struct packed {
		logic [ADDR_W-1:0]  addr;
		logic [1:0]         access_size;
		logic               write_not_read;
		logic               instr_fetch_low;
		logic               mem_request_low;
		logic               burst_continue_flag;
		logic               compact_state_flag;
	} cbs_bus_t;

	typedef struct packed {
		logic               pc_advance;
		logic               dest_write;
		logic               flags_update;
		logic               exc_ignore;
		logic               done;
	} cbs_side_t;

endpackage

/* File: cbs_addr_step.sv */
// Purpose: address adder, base plus a count of instruction widths
// Assumes: width is 2 or 4 bytes
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none

module cbs_addr_step
	import cbs_pkg::*;
(
	input  wire logic [ADDR_W-1:0] base,
	input  wire logic [1:0]        step,
	input  wire logic [ADDR_W-1:0] width,
	output logic      [ADDR_W-1:0] sum
);

	always_comb begin
		case (step)
			STEP_0:  sum = base;
			STEP_1:  sum = base + width;
			STEP_2:  sum = base + (width << 1);
			STEP_3:  sum = base + (width << 1) + width;
			default: sum = base;
		endcase
	end

endmodule

`default_nettype wire

/* File: cbs_op_timing.sv */
// Purpose: length of an issued instruction in rows, and legality in the current state
// Assumes: mul_m is at least one
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none

module cbs_op_timing
	import cbs_pkg::*;
(
	input  wire cbs_issue_t       ir,
	input  wire logic             compact,
	output logic      [CNT_W-1:0] total,
	output logic                  illegal
);

	logic [CNT_W-1:0] m_ext;

	always_comb begin
		m_ext   = CNT_W'(ir.mul_m);
		total   = CYCLE_1;
		illegal = 1'b0;
		case (ir.op)
			OP_BR_SWITCH: total = CYCLE_3;
			OP_DATA: begin
				if (ir.dest_pc && ir.shift_reg) begin
					total   = CYCLE_4;
					illegal = compact;
				end else if (ir.dest_pc) begin
					total = CYCLE_3;
				end else if (ir.shift_reg) begin
					total = CYCLE_2;
				end else begin
					total = CYCLE_1;
				end
			end
			OP_STAT_READ, OP_STAT_WRITE: begin
				total = ir.shift_reg ? CYCLE_2 : CYCLE_1;
			end
			OP_MUL: total = m_ext + CYCLE_1 + MUL_EXTRA_NONE;
			OP_MLA, OP_MULL: begin
				total   = m_ext + CYCLE_1 + MUL_EXTRA_ONE;
				illegal = compact;
			end
			OP_MLAL: begin
				total   = m_ext + CYCLE_1 + MUL_EXTRA_TWO;
				illegal = compact;
			end
			default: total = CYCLE_1;
		endcase
	end

endmodule

`default_nettype wire

/* File: cbs_sequencer_assertions.sv */
// Purpose: concurrent checks on the sequencer ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every cbs_sequencer instance
`timescale 1ns/10ps
`default_nettype none

module cbs_sequencer_assertions
	import cbs_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       issue_valid,
	input wire cbs_issue_t issue,
	input wire logic       mem_wait,
	input wire logic       issue_ready,
	input wire logic       issue_reject,
	input wire cbs_bus_t   bus,
	input wire cbs_side_t  side
);
	// ****************************************
	// offers the sequencer must refuse
	// ****************************************
	logic illegal;
	assign illegal = bus.compact_state_flag && (issue.op inside {OP_MLA, OP_MULL, OP_MLAL}
		|| (issue.op == OP_DATA && issue.dest_pc && issue.shift_reg));

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_accept;
		issue_valid && issue_ready && !illegal;
	endsequence
	sequence s_ann_int;
		bus.mem_request_low && !bus.instr_fetch_low && !mem_wait;
	endsequence
	sequence s_int_row;
		bus.instr_fetch_low;
	endsequence

	a_size_not_rsvd: assert property (bus.access_size != 2'h3)
		else $error("reserved access size driven");
	a_size_follows_state: assert property (bus.access_size == (bus.compact_state_flag ? 2'h1 : 2'h2))
		else $error("access size disagrees with state flag");
	a_wait_holds_bus: assert property (mem_wait |=> $stable(bus) && $stable(side))
		else $error("row moved during wait");
	a_wait_blocks_issue: assert property (mem_wait |-> !issue_ready)
		else $error("ready during wait");
	a_first_row_addr: assert property (s_accept |=> !bus.instr_fetch_low
		&& bus.addr == $past(issue.pc) + (bus.compact_state_flag ? 32'h4 : 32'h8))
		else $error("first row not a prefetch at pc plus two widths");
	a_flag_change_row: assert property (!$stable(bus.compact_state_flag) && !$past(rst) |->
		bus.burst_continue_flag && $past(!bus.burst_continue_flag && !bus.mem_request_low))
		else $error("state flag changed outside branch second row");
	a_internal_follows: assert property (s_ann_int |=> s_int_row)
		else $error("announced internal cycle fetched");
	a_last_internal_seq: assert property (side.done && bus.instr_fetch_low |->
		!bus.mem_request_low && bus.burst_continue_flag)
		else $error("final internal row does not announce sequential fetch");
	a_refill_step: assert property (bus.burst_continue_flag && !bus.instr_fetch_low
		&& !side.done && !mem_wait |=> bus.addr == $past(bus.addr)
		+ (bus.compact_state_flag ? 32'h2 : 32'h4))
		else $error("refill fetch not one width on");
	a_reject_cause: assert property (issue_reject |-> $past(issue_valid && illegal))
		else $error("reject without illegal offer");
endmodule

bind cbs_sequencer cbs_sequencer_assertions cbs_sequencer_assertions_i (.clk(clk), .rst(rst),
	.issue_valid(issue_valid), .issue(issue), .mem_wait(mem_wait), .issue_ready(issue_ready),
	.issue_reject(issue_reject), .bus(bus), .side(side));
`default_nettype wire

/* File: cbs_mem_model.sv */
// Purpose: memory system model that stretches requested cycles
// Assumes: slow asks for one wait cycle on each stretchable access
// Notes:   an access right after an internal cycle is merged and never stretched
`timescale 1ns/10ps
`default_nettype none

module cbs_mem_model
	import cbs_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire logic     slow,
	input  wire cbs_bus_t bus,
	output logic          mem_wait
);
	logic wait_r;
	logic wait_nxt;
	logic int_r;
	logic int_nxt;

	always_comb begin
		int_nxt = wait_r ? int_r : bus.mem_request_low;
		wait_nxt = slow && !bus.mem_request_low && !wait_r && !int_r;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wait_r <= 1'h0;
			int_r  <= 1'h0;
		end else begin
			wait_r <= wait_nxt;
			int_r  <= int_nxt;
		end
	end

	assign mem_wait = wait_r;
endmodule
`default_nettype wire

/* File: test_core_bus_cycle_sequencer.sv */
// Purpose: self-checking bench for the bus-cycle sequencer
// Assumes: memory model supplies mem_wait
// Notes:   rows are collected whenever a cycle completes without wait
`timescale 1ns/10ps
`default_nettype none

module test_core_bus_cycle_sequencer
	import cbs_pkg::*;
;
	typedef struct packed {
		cbs_op_t     op;
		logic [2:0]  f;
		logic [2:0]  m;
		logic [31:0] tgt;
		logic        slow;
		logic [3:0]  n;
	} cbs_case_t;

	logic       clk;
	logic       rst;
	logic       issue_valid;
	logic       mem_wait;
	logic       issue_ready;
	logic       issue_reject;
	logic       slow;
	logic       cstate;
	cbs_issue_t issue;
	cbs_bus_t   bus;
	cbs_side_t  side;
	int         mismatches;
	int         checks;

	// f holds dest_pc, shift_reg, compare
	cbs_case_t cases [18] = '{
		'{OP_DATA, 3'h0, 3'h0, 32'h0, 1'h0, 4'h1}, '{OP_DATA, 3'h1, 3'h0, 32'h0, 1'h0, 4'h1},
		'{OP_DATA, 3'h2, 3'h0, 32'h0, 1'h1, 4'h2}, '{OP_DATA, 3'h4, 3'h0, 32'h2000, 1'h0, 4'h3},
		'{OP_DATA, 3'h6, 3'h0, 32'h3000, 1'h1, 4'h4}, '{OP_STAT_READ, 3'h0, 3'h0, 32'h0, 1'h0, 4'h1},
		'{OP_STAT_WRITE, 3'h4, 3'h0, 32'h0, 1'h0, 4'h1}, '{OP_MUL, 3'h0, 3'h1, 32'h0, 1'h0, 4'h2},
		'{OP_MUL, 3'h0, 3'h7, 32'h0, 1'h1, 4'h8}, '{OP_MLA, 3'h0, 3'h2, 32'h0, 1'h0, 4'h4},
		'{OP_MULL, 3'h0, 3'h3, 32'h0, 1'h0, 4'h5}, '{OP_MLAL, 3'h0, 3'h2, 32'h0, 1'h0, 4'h5},
		'{OP_BR_SWITCH, 3'h0, 3'h0, 32'h4001, 1'h1, 4'h3}, '{OP_DATA, 3'h2, 3'h0, 32'h0, 1'h0, 4'h2},
		'{OP_DATA, 3'h5, 3'h0, 32'h5000, 1'h1, 4'h3}, '{OP_MUL, 3'h0, 3'h3, 32'h0, 1'h0, 4'h4},
		'{OP_BR_SWITCH, 3'h0, 3'h0, 32'h6000, 1'h0, 4'h3},
		'{OP_BR_SWITCH, 3'h0, 3'h0, 32'h7001, 1'h0, 4'h3}};
	cbs_op_t bad [4] = '{OP_MLA, OP_MULL, OP_MLAL, OP_DATA};

	cbs_sequencer cbs_sequencer_i (.clk(clk), .rst(rst), .issue_valid(issue_valid), .issue(issue),
		.mem_wait(mem_wait), .issue_ready(issue_ready), .issue_reject(issue_reject), .bus(bus),
		.side(side));
	cbs_mem_model cbs_mem_model_i (.clk(clk), .rst(rst), .slow(slow), .bus(bus),
		.mem_wait(mem_wait));

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(logic [63:0] got, logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// row address and {request_low, sequential, fetch_low}
	function automatic logic [34:0] exp_row(cbs_case_t c, logic [31:0] pc, logic cs, int k);
		logic [31:0] l;
		logic [31:0] t;
		logic [31:0] a2;
		logic [31:0] a3;
		l = cs ? 32'h2 : 32'h4;
		t = c.tgt & 32'hFFFFFFFE;
		a2 = pc + 2 * l;
		a3 = pc + 3 * l;
		if (c.op == OP_BR_SWITCH)
			return (k == 1) ? {a2, 3'h0} : {t + (k - 2) * (c.tgt[0] ? 32'h2 : 32'h4), 3'h2};
		if (c.op >= OP_MUL) begin
			if (k == 1) return {a2, 3'h4};
			if (k == c.n) return {a3, 3'h3};
			return {(k == 2 && c.op inside {OP_MLA, OP_MLAL}) ? a2 : a3, 3'h5};
		end
		if (c.f[2] && c.op == OP_DATA) begin
			if (k == 1) return {a2, c.f[1], 2'h0};
			if (c.f[1] && k == 2) return {a3, 3'h1};
			return {t + (k - 2 - c.f[1]) * l, 3'h2};
		end
		if (c.f[1]) return (k == 1) ? {a2, 3'h4} : {a3, 3'h3};
		return {a2, 3'h2};
	endfunction

	task automatic reset_and_check();
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		chk({bus, side, issue_reject, issue_ready}, {32'h0, 2'h2, 5'hC, 5'h0, 2'h1});
		cstate = 1'h0;
		$display("reset test done at %0t", $time);
	endtask

	task automatic run_op(cbs_case_t c, logic [31:0] pc);
		logic [35:0] row;
		logic [35:0] e;
		logic [2:0]  sz;
		logic [3:0]  acc;
		logic        nf;
		int          k;
		acc = 4'h0;
		slow <= c.slow;
		issue <= '{op: c.op, dest_pc: c.f[2], shift_reg: c.f[1], compare: c.f[0], pc: pc,
			target: c.tgt, mul_m: c.m};
		issue_valid <= 1'h1;
		@(posedge clk);
		for (k = 0; k < 20 && issue_ready !== 1'h1; k++) @(posedge clk);
		issue_valid <= 1'h0;
		k = 0;
		while (k < c.n) begin
			@(posedge clk);
			if (mem_wait === 1'h0) begin
				k++;
				nf = (c.op == OP_BR_SWITCH && k > 1) ? c.tgt[0] : cstate;
				sz = nf ? 3'h3 : 3'h4;
				row = {bus.addr, bus.mem_request_low, bus.burst_continue_flag,
					bus.instr_fetch_low, side.done};
				e = {exp_row(c, pc, cstate, k), k == c.n};
				chk(row, e);
				chk({bus.access_size, bus.compact_state_flag, bus.write_not_read}, {sz, 1'h0});
				acc |= {side.pc_advance, side.dest_write, side.flags_update, side.exc_ignore};
			end
		end
		e = {1'h1, !c.f[0] && c.op != OP_STAT_WRITE, c.op == OP_DATA, c.f[2] && c.op == OP_DATA};
		if (c.op <= OP_STAT_WRITE)
			chk(acc, e);
		else
			chk(acc, {c.op != OP_BR_SWITCH, c.op >= OP_MUL, 2'h0});
		if (c.op == OP_BR_SWITCH)
			cstate = c.tgt[0];
		$display("op %0d done at %0t", c.op, $time);
	endtask

	// ****************************************
	// clock, watchdog and sequence
	// ****************************************
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end

	initial begin
		rst = 1'h1;
		issue_valid = 1'h0;
		issue = '0;
		slow = 1'h0;
		cstate = 1'h0;
		mismatches = 0;
		checks = 0;
		reset_and_check();
		foreach (cases[i]) run_op(cases[i], 32'h100 + 32'h40 * i);
		foreach (bad[j]) begin
			issue <= '{op: bad[j], dest_pc: 1'h1, shift_reg: 1'h1, compare: 1'h0, pc: 32'h800,
				target: 32'h0, mul_m: 3'h2};
			issue_valid <= 1'h1;
			@(posedge clk);
			issue_valid <= 1'h0;
			@(posedge clk);
			chk({issue_reject, bus.instr_fetch_low, bus.mem_request_low}, 3'h7);
			@(posedge clk);
			chk(issue_reject, 1'h0);
		end
		$display("reject test done at %0t", $time);
		issue <= '{op: OP_MUL, dest_pc: 1'h0, shift_reg: 1'h0, compare: 1'h0, pc: 32'h900,
			target: 32'h0, mul_m: 3'h7};
		issue_valid <= 1'h1;
		@(posedge clk);
		issue_valid <= 1'h0;
		repeat (3) @(posedge clk);
		reset_and_check();
		tally_and_finish();
	end
endmodule
`default_nettype wire
